// ===== design/swcr_defines.vh
// register map, field positions and timing constants of the selective wake bank
`ifndef SWCR_DEFINES_VH
`define SWCR_DEFINES_VH

`define SWCR_ADDR_W 7
`define SWCR_ADDR_PAYLOAD3 7'h30
`define SWCR_ADDR_PAYLOAD2 7'h31
`define SWCR_ADDR_PAYLOAD1 7'h32
`define SWCR_ADDR_PAYLOAD0 7'h33
`define SWCR_ADDR_FD_CFG 7'h34
`define SWCR_ADDR_FINE_TRIM 7'h38
`define SWCR_ADDR_RX_OPT 7'h39
`define SWCR_ADDR_CAL_HIGH 7'h3a
`define SWCR_ADDR_CAL_LOW 7'h3b

`define SWCR_BYTE_RESET 8'h00
`define SWCR_FD_CFG_RESET 6'h00

// fd tolerance config fields
`define SWCR_FD_ERRDIS_BIT 5
`define SWCR_FD_BYPASS_BIT 4
`define SWCR_FD_TIME_HI 3
`define SWCR_FD_TIME_LO 1
`define SWCR_FD_ENABLE_BIT 0
`define SWCR_FD_WRITABLE 6'h3f

// receiver options fields
`define SWCR_OPT_RXSEL_BIT 7
`define SWCR_OPT_COARSE_HI 4
`define SWCR_OPT_COARSE_LO 0
`define SWCR_TRIM_UNLOCK 2'h3

// frame layout: 7 address bits, write flag, 8 data bits, msb first
`define SWCR_FRAME_BITS 5'h10
`define SWCR_HDR_BITS 5'h08
`define SWCR_CNT_W 5

// dominant filter timing
`define SWCR_CLK_PERIOD_NS 10
`define SWCR_DOM_STEP_NS 50
`define SWCR_DOM_LONG_NS 775
`define SWCR_DOM_LONG_CODE 3'h7
`define SWCR_DOM_CNT_W 7

`endif

// ===== design/swcr_spi_slave.v
// serial frame receiver and read data shifter for the register bank
`default_nettype none
`include "swcr_defines.vh"

module swcr_spi_slave (
  input wire clock,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_mosi,
  input wire [7:0] rd_data,
  output reg spi_miso,
  output reg spi_miso_oe,
  output reg [`SWCR_ADDR_W-1:0] addr_q,
  output reg wr_en,
  output reg [7:0] wr_data
);

  reg sck_prev_q;
  reg cs_prev_q;
  reg [`SWCR_CNT_W-1:0] cnt_q;
  reg [15:0] shin_q;
  reg [7:0] shout_q;
  reg is_write_q;
  wire sck_rise;
  wire sck_fall;
  wire cs_end;

  assign sck_rise = ~spi_cs_n & spi_sck & ~sck_prev_q;
  assign sck_fall = ~spi_cs_n & ~spi_sck & sck_prev_q;
  assign cs_end = spi_cs_n & ~cs_prev_q;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      cnt_q <= {`SWCR_CNT_W{1'b0}};
      shin_q <= 16'h0000;
      shout_q <= 8'h00;
      is_write_q <= 1'b0;
      addr_q <= {`SWCR_ADDR_W{1'b0}};
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else
    begin
      sck_prev_q <= spi_sck;
      cs_prev_q <= spi_cs_n;
      spi_miso_oe <= ~spi_cs_n;
      wr_en <= 1'b0;
      if (spi_cs_n)
      begin
        cnt_q <= {`SWCR_CNT_W{1'b0}};
        spi_miso <= 1'b0;
      end
      if (sck_rise)
      begin
        shin_q <= {shin_q[14:0], spi_mosi};
        if (cnt_q != `SWCR_FRAME_BITS)
          cnt_q <= cnt_q + 1'b1;
        if (cnt_q == `SWCR_HDR_BITS - 1'b1)
        begin
          addr_q <= shin_q[`SWCR_ADDR_W-1:0];
          is_write_q <= spi_mosi;
        end
      end
      // read data loads once the header is in, shifts out msb first
      if (sck_fall)
      begin
        if (cnt_q == `SWCR_HDR_BITS)
        begin
          spi_miso <= rd_data[7];
          shout_q <= {rd_data[6:0], 1'b0};
        end
        else
        begin
          spi_miso <= shout_q[7];
          shout_q <= {shout_q[6:0], 1'b0};
        end
      end
      // only a frame of at least the full 16 bits commits a write
      if (cs_end && cnt_q == `SWCR_FRAME_BITS && is_write_q)
      begin
        wr_en <= 1'b1;
        wr_data <= shin_q[7:0];
      end
    end
  end

endmodule // swcr_spi_slave
`default_nettype wire

// ===== design/swcr_dom_filter.v
// digital dominant pulse suppression on the wake receive path
`default_nettype none
`include "swcr_defines.vh"

module swcr_dom_filter (
  input wire clock,
  input wire rst_n,
  input wire [2:0] time_code,
  input wire rxd_in,
  output reg rxd_out
);

  reg [`SWCR_DOM_CNT_W-1:0] cnt_q;
  wire [`SWCR_DOM_CNT_W-1:0] limit;

  // least time, rounded up to whole clock cycles
  function [`SWCR_DOM_CNT_W-1:0] dom_cycles;
    input [2:0] code;
    integer ns;
    integer cyc;
    begin
      if (code == `SWCR_DOM_LONG_CODE)
        ns = `SWCR_DOM_LONG_NS;
      else
        ns = `SWCR_DOM_STEP_NS * (code + 1);
      // divide before cutting to width, the long code exceeds the counter range in ns
      cyc = (ns + `SWCR_CLK_PERIOD_NS - 1) / `SWCR_CLK_PERIOD_NS;
      dom_cycles = cyc[`SWCR_DOM_CNT_W-1:0];
    end
  endfunction

  assign limit = dom_cycles(time_code); // R6

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= {`SWCR_DOM_CNT_W{1'b0}};
      rxd_out <= 1'b1;
    end
    else if (rxd_in)
    begin
      cnt_q <= {`SWCR_DOM_CNT_W{1'b0}};
      rxd_out <= 1'b1;
    end
    else
    begin
      if (cnt_q < limit)
        cnt_q <= cnt_q + 1'b1;
      if (cnt_q + 1'b1 >= limit)
        rxd_out <= 1'b0; // R6
    end
  end

endmodule // swcr_dom_filter
`default_nettype wire

// ===== design/swcr_regs.v
// selective wake payload, fd tolerance, trim and calibration register bank
// Summary of operation
// R1: payload bytes rw, cleared by reset and by soft reset
// R2: reserved bits read back as zero
// R3: error counter suspended only with fd mode enabled
// R4: silence timeout clears error counter disable bit
// R5: bypass bit routes receiver around analog filter
// R6: filter code selects 50-350 ns or 775 ns
// R7: dominant filter applies even when bypassed
// R8: bit zero enables fd tolerant mode
// R9: trim code writable only when unlock is 11
// R10: trim bits 0-4 are monotonic fine step
// R11: software keeps temperature trim bits 5-7
// R12: receiver select bit, unlocked access only
// R13: software should pick the low power receiver
// R14: software rewrites coarse trim with receiver select
// R15: options bits 4:0 hold coarse trim code
// R16: calibration registers read only, reset to zero
// R17: fine trim register has no reset value
// R18: writes to read only or reserved ignored
`default_nettype none
`include "swcr_defines.vh"

module swcr_regs (
  input wire clock,
  input wire rst_n,
  input wire soft_reset,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  input wire [1:0] trim_unlock,
  input wire silence_timeout,
  input wire cal_update,
  input wire [7:0] cal_high_in,
  input wire [7:0] cal_low_in,
  input wire rxd_analog,
  input wire rxd_unfiltered,
  output reg rxd_wake,
  output reg error_counter_suspend,
  output reg [12:0] oscillator_trim_code,
  output reg wake_receiver_select,
  output reg [7:0] payload_byte_zero,
  output reg [7:0] payload_byte_one,
  output reg [7:0] payload_byte_two,
  output reg [7:0] payload_byte_three
);

  wire [`SWCR_ADDR_W-1:0] addr;
  wire wr_en;
  wire [7:0] wr_data;
  reg [7:0] rd_data;
  reg [7:0] payload0_q;
  reg [7:0] payload1_q;
  reg [7:0] payload2_q;
  reg [7:0] payload3_q;
  reg [5:0] fd_cfg_q;
  reg [7:0] fine_trim_q;
  reg [4:0] coarse_trim_q;
  reg rx_sel_q;
  reg [7:0] cal_high_q;
  reg [7:0] cal_low_q;
  reg rxd_sel;
  wire unlocked;
  wire rxd_filt;

  function wr_hit;
    input en;
    input [`SWCR_ADDR_W-1:0] a;
    input [`SWCR_ADDR_W-1:0] target;
    begin
      wr_hit = en & (a == target);
    end
  endfunction

  assign unlocked = (trim_unlock == `SWCR_TRIM_UNLOCK);

  swcr_spi_slave u_spi (
    .clock(clock),
    .rst_n(rst_n),
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .spi_mosi(spi_mosi),
    .rd_data(rd_data),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .addr_q(addr),
    .wr_en(wr_en),
    .wr_data(wr_data)
  );

  // payload bytes
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      payload0_q <= `SWCR_BYTE_RESET;
      payload1_q <= `SWCR_BYTE_RESET;
      payload2_q <= `SWCR_BYTE_RESET;
      payload3_q <= `SWCR_BYTE_RESET;
    end
    else if (soft_reset)
    begin
      payload0_q <= `SWCR_BYTE_RESET; // R1
      payload1_q <= `SWCR_BYTE_RESET; // R1
      payload2_q <= `SWCR_BYTE_RESET; // R1
      payload3_q <= `SWCR_BYTE_RESET; // R1
    end
    else
    begin
      if (wr_hit(wr_en, addr, `SWCR_ADDR_PAYLOAD0))
        payload0_q <= wr_data; // R1
      if (wr_hit(wr_en, addr, `SWCR_ADDR_PAYLOAD1))
        payload1_q <= wr_data; // R1
      if (wr_hit(wr_en, addr, `SWCR_ADDR_PAYLOAD2))
        payload2_q <= wr_data; // R1
      if (wr_hit(wr_en, addr, `SWCR_ADDR_PAYLOAD3))
        payload3_q <= wr_data; // R1
    end
  end

  // fd tolerance config; the timeout clear takes precedence over a write
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fd_cfg_q <= `SWCR_FD_CFG_RESET;
    else if (soft_reset)
      fd_cfg_q <= `SWCR_FD_CFG_RESET; // R8
    else
    begin
      if (wr_hit(wr_en, addr, `SWCR_ADDR_FD_CFG))
        fd_cfg_q <= wr_data[5:0] & `SWCR_FD_WRITABLE; // R18
      if (silence_timeout)
        fd_cfg_q[`SWCR_FD_ERRDIS_BIT] <= 1'b0; // R4
    end
  end

  // fine trim holds whatever it powers up with
  always @(posedge clock)
  begin
    if (wr_hit(wr_en, addr, `SWCR_ADDR_FINE_TRIM) && unlocked)
      fine_trim_q <= wr_data; // R9 R17
  end

  // coarse trim also unreset; receiver select resets low
  always @(posedge clock)
  begin
    if (wr_hit(wr_en, addr, `SWCR_ADDR_RX_OPT) && unlocked)
      coarse_trim_q <= wr_data[`SWCR_OPT_COARSE_HI:`SWCR_OPT_COARSE_LO]; // R9 R15
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rx_sel_q <= 1'b0;
    else if (soft_reset)
      rx_sel_q <= 1'b0;
    else if (wr_hit(wr_en, addr, `SWCR_ADDR_RX_OPT) && unlocked)
      rx_sel_q <= wr_data[`SWCR_OPT_RXSEL_BIT]; // R12
  end

  // calibration status, loaded by hardware only
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_high_q <= `SWCR_BYTE_RESET;
      cal_low_q <= `SWCR_BYTE_RESET;
    end
    else if (soft_reset)
    begin
      cal_high_q <= `SWCR_BYTE_RESET; // R16
      cal_low_q <= `SWCR_BYTE_RESET; // R16
    end
    else if (cal_update)
    begin
      cal_high_q <= cal_high_in; // R16 R18
      cal_low_q <= cal_low_in; // R16 R18
    end
  end

  // read mux
  always @*
  begin
    rd_data = 8'h00;
    case (addr)
      `SWCR_ADDR_PAYLOAD0: rd_data = payload0_q;
      `SWCR_ADDR_PAYLOAD1: rd_data = payload1_q;
      `SWCR_ADDR_PAYLOAD2: rd_data = payload2_q;
      `SWCR_ADDR_PAYLOAD3: rd_data = payload3_q;
      `SWCR_ADDR_FD_CFG: rd_data = {2'h0, fd_cfg_q}; // R2
      `SWCR_ADDR_FINE_TRIM: rd_data = fine_trim_q;
      `SWCR_ADDR_RX_OPT: rd_data = {rx_sel_q & unlocked, 2'h0, coarse_trim_q}; // R2 R12
      `SWCR_ADDR_CAL_HIGH: rd_data = cal_high_q;
      `SWCR_ADDR_CAL_LOW: rd_data = cal_low_q;
      default: rd_data = 8'h00;
    endcase
  end

  // bypass picks the path ahead of the digital filter
  always @*
  begin
    if (fd_cfg_q[`SWCR_FD_BYPASS_BIT])
      rxd_sel = rxd_unfiltered; // R5
    else
      rxd_sel = rxd_analog; // R5
  end

  swcr_dom_filter u_filt (
    .clock(clock),
    .rst_n(rst_n),
    .time_code(fd_cfg_q[`SWCR_FD_TIME_HI:`SWCR_FD_TIME_LO]),
    .rxd_in(rxd_sel),
    .rxd_out(rxd_filt)
  );

  // registered outputs
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_wake <= 1'b1;
      error_counter_suspend <= 1'b0;
      oscillator_trim_code <= 13'h0000;
      wake_receiver_select <= 1'b0;
      payload_byte_zero <= `SWCR_BYTE_RESET;
      payload_byte_one <= `SWCR_BYTE_RESET;
      payload_byte_two <= `SWCR_BYTE_RESET;
      payload_byte_three <= `SWCR_BYTE_RESET;
    end
    else
    begin
      rxd_wake <= rxd_filt; // R7
      error_counter_suspend <= fd_cfg_q[`SWCR_FD_ERRDIS_BIT]
                               & fd_cfg_q[`SWCR_FD_ENABLE_BIT]; // R3 R8
      oscillator_trim_code <= {coarse_trim_q, fine_trim_q}; // R10 R15
      wake_receiver_select <= rx_sel_q; // R12
      payload_byte_zero <= payload0_q;
      payload_byte_one <= payload1_q;
      payload_byte_two <= payload2_q;
      payload_byte_three <= payload3_q;
    end
  end

endmodule // swcr_regs
`default_nettype wire

// ===== verification/swcr_regs_sva.sv
// port assertions for the selective wake register bank
`default_nettype none
module swcr_regs_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic spi_cs_n,
  input wire logic [1:0] trim_unlock,
  input wire logic silence_timeout,
  input wire logic rxd_analog,
  input wire logic rxd_unfiltered,
  input wire logic rxd_wake,
  input wire logic error_counter_suspend,
  input wire logic [12:0] oscillator_trim_code,
  input wire logic wake_receiver_select,
  input wire logic [7:0] payload_byte_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  // run length of dominant samples on either receive line
  logic [6:0] dom_q;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      dom_q <= 7'h00;
    else if (rxd_analog && rxd_unfiltered)
      dom_q <= 7'h00;
    else if (dom_q != 7'h7f)
      dom_q <= dom_q + 7'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  payload_hold_a: assert property (
    $changed(payload_byte_zero) |-> $past(spi_cs_n, 2) || $past(soft_reset, 2))
    else $error("payload moved outside a write");
  payload_clear_a: assert property (
    soft_reset |-> ##2 payload_byte_zero == 8'h00 && !wake_receiver_select)
    else $error("soft reset did not clear");
  silence_clear_a: assert property (
    silence_timeout |-> ##2 !error_counter_suspend)
    else $error("silence did not end suspend");
  suspend_rise_a: assert property (
    $rose(error_counter_suspend) |-> $past(spi_cs_n, 2))
    else $error("suspend rose without a write");
  dom_min_a: assert property (
    $fell(rxd_wake) |-> dom_q >= 7'h06)
    else $error("dominant passed too early");
  dom_release_a: assert property (
    $rose(rxd_wake) |-> dom_q == 7'h00)
    else $error("recessive without input");
  trim_lock_a: assert property (
    $changed(oscillator_trim_code) |-> trim_unlock == 2'h3)
    else $error("trim changed while locked");
  rxsel_lock_a: assert property (
    $changed(wake_receiver_select) |-> trim_unlock == 2'h3 || $past(soft_reset, 2))
    else $error("receiver select changed while locked");
  cover property ($fell(rxd_wake));
  cover property ($rose(error_counter_suspend));
  cover property ($changed(oscillator_trim_code));
endmodule // swcr_regs_sva
bind swcr_regs swcr_regs_sva swcr_regs_sva_i (.clock, .rst_n, .soft_reset, .spi_cs_n,
  .trim_unlock, .silence_timeout, .rxd_analog, .rxd_unfiltered, .rxd_wake,
  .error_counter_suspend, .oscillator_trim_code, .wake_receiver_select, .payload_byte_zero);
`default_nettype wire

// ===== verification/swcr_host.sv
// serial master model of the host controller
`default_nettype none
module swcr_host (
  input wire logic clock,
  input wire logic spi_miso,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  // n below 16 makes an aborted frame
  task automatic xfer(input logic [15:0] f, input int n);
    logic [7:0] r;
    r = 8'h00;
    @(posedge clock) spi_cs_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      spi_mosi <= f[i];
      repeat (4) @(posedge clock);
      r = {r[6:0], spi_miso};
      spi_sck <= 1'b1;
      repeat (2) @(posedge clock);
      spi_sck <= 1'b0;
      @(posedge clock);
    end
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (6) @(posedge clock);
    if (n == 16 && !f[8])
    begin
      rd_data <= r;
      rd_valid <= 1'b1;
      @(posedge clock) rd_valid <= 1'b0;
    end
  endtask
endmodule // swcr_host
`default_nettype wire

// ===== verification/swcr_regs_tb.sv
// self-checking bench for the selective wake register bank
`default_nettype none
module swcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic silence_timeout = 1'b0;
  logic cal_update = 1'b0;
  logic rxd_analog = 1'b1;
  logic rxd_unfiltered = 1'b1;
  logic [1:0] trim_unlock = 2'h3;
  logic [7:0] cal_high_in = 8'h00;
  logic [7:0] cal_low_in = 8'h00;
  logic spi_cs_n, spi_sck, spi_mosi, spi_miso, rxd_wake, error_counter_suspend;
  logic wake_receiver_select, rd_valid;
  logic [7:0] rd_data;
  logic [12:0] oscillator_trim_code;
  logic [7:0] pb[4];
  logic [7:0] pl[4];
  logic [7:0] expq[$];
  logic [31:0] lfsr = 32'hb8a50517;
  int fails = 0;
  int num_checks = 0;
  int n;
  initial
    forever #5 clock = ~clock;
  swcr_regs swcr_regs_i (.clock, .rst_n, .soft_reset, .spi_cs_n, .spi_sck, .spi_mosi,
    .spi_miso, .spi_miso_oe(), .trim_unlock, .silence_timeout, .cal_update,
    .cal_high_in, .cal_low_in, .rxd_analog, .rxd_unfiltered, .rxd_wake,
    .error_counter_suspend, .oscillator_trim_code, .wake_receiver_select,
    .payload_byte_zero(pb[0]), .payload_byte_one(pb[1]), .payload_byte_two(pb[2]),
    .payload_byte_three(pb[3]));
  swcr_host swcr_host_i (.clock, .spi_miso, .spi_cs_n, .spi_sck, .spi_mosi, .rd_valid,
    .rd_data);
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    swcr_host_i.xfer({a, 1'b1, d}, 16);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expq.push_back(e);
    swcr_host_i.xfer({a, 1'b0, 8'h00}, 16);
  endtask
  always @(posedge clock)
    if (rd_valid === 1'b1)
      check(rd_data, expq.pop_front());
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200us;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int a = 8'h30; a < 8'h3c; a++)
      if (a != 8'h38 && a != 8'h39)
        rd(a[6:0], 8'h00);
    foreach (pl[i])
    begin
      pl[i] = rnd();
      wr(7'(7'h33 - i), pl[i]);
    end
    swcr_host_i.xfer({7'h33, 1'b1, ~pl[0]}, 8);
    foreach (pl[i])
      rd(7'(7'h33 - i), pl[i]);
    foreach (pb[i])
      check(pb[i], pl[i]);
    wr(7'h34, 8'hff);
    rd(7'h34, 8'h3f);
    check(error_counter_suspend, 1'b1);
    silence_timeout <= 1'b1;
    @(posedge clock) silence_timeout <= 1'b0;
    repeat (3) @(posedge clock);
    check(error_counter_suspend, 1'b0);
    rd(7'h34, 8'h1f);
    wr(7'h34, 8'h20);
    check(error_counter_suspend, 1'b0);
    wr(7'h38, 8'h5a);
    wr(7'h39, 8'hf3);
    check(oscillator_trim_code, 13'h135a);
    check(wake_receiver_select, 1'b1);
    rd(7'h39, 8'h93);
    trim_unlock <= 2'h0;
    wr(7'h38, 8'h45);
    wr(7'h39, 8'h13);
    check(oscillator_trim_code, 13'h135a);
    check(wake_receiver_select, 1'b1);
    rd(7'h39, 8'h13);
    rd(7'h38, 8'h5a);
    cal_high_in <= rnd();
    cal_low_in <= rnd();
    cal_update <= 1'b1;
    @(posedge clock) cal_update <= 1'b0;
    wr(7'h3a, ~cal_high_in);
    rd(7'h3a, cal_high_in);
    rd(7'h3b, cal_low_in);
    soft_reset <= 1'b1;
    @(posedge clock) soft_reset <= 1'b0;
    repeat (3) @(posedge clock);
    foreach (pb[i])
      check(pb[i], 8'h00);
    check(wake_receiver_select, 1'b0);
    rd(7'h3b, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(7'h34, {3'h0, c[0], c[2:0], 1'b0});
      rxd_analog <= c[0];
      rxd_unfiltered <= !c[0];
      n = 0;
      while (rxd_wake !== 1'b0 && n < 90)
      begin
        @(posedge clock);
        n++;
      end
      check(13'(n), 13'(c == 7 ? 80 : 5 * c + 7));
      rxd_analog <= 1'b1;
      rxd_unfiltered <= 1'b1;
      repeat (6) @(posedge clock);
      check(rxd_wake, 1'b1);
    end
    stop_test();
  end
endmodule // swcr_regs_tb
`default_nettype wire
